//--- csp_shift_port.sv
// Clocked serial shift port with shared general port pins
`timescale 1ns/100ps
module csp_shift_port
	import csp_pkg::*;
#(
	parameter bit POS_POL = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register port
	input wire logic [15:0] addr_i,
	input wire logic [3:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [3:0] rdata_o,
	// Clock sources, one-cycle pulses
	input wire logic osc_tick_i,
	input wire logic tmr2_uf_i,
	// General port side
	input wire logic [3:0] gpio_out_i,
	input wire logic [3:0] gpio_oe_i,
	// Shared pins
	input wire logic [3:0] pin_in_i,
	output logic [3:0] pin_out_o,
	output logic [3:0] pin_oe_o,
	// Interrupt request
	output logic irq_o
);

	csp_state_t st;
	csp_state_t next_st;
	logic trig;
	logic master;
	logic mtick;
	logic lvl;
	logic rise;
	logic fall;
	logic samp;
	logic obit;
	logic [7:0] shin;

	// Clock pin level seen as active-high, whatever the build polarity
	assign lvl = POS_POL ? pin_in_i[CSP_P_SCLK] : ~pin_in_i[CSP_P_SCLK];
	assign master = st.mode != CSP_M_SLAVE;
	assign trig = wr_i && addr_i == CSP_A_CTRL && wdata_i[CSP_B_TRIG];

	// Master half-period tick per mode; timer underflow toggles the
	// clock, so a full cycle spans two underflows
	always_comb begin
		unique case (st.mode)
			CSP_M_OSC: mtick = osc_tick_i;
			CSP_M_HALF: mtick = osc_tick_i && st.div;
			CSP_M_TIMER: mtick = tmr2_uf_i;
			CSP_M_SLAVE: mtick = 1'b0;
		endcase
	end

	// Active edges; after the eighth cycle run drops and masks them
	always_comb begin
		if (master) begin
			rise = st.run && mtick && !st.clk;
			fall = st.run && mtick && st.clk;
		end else begin
			rise = st.run && lvl && !st.pclk;
			fall = st.run && !lvl && st.pclk;
		end
	end

	// Bit order steers which end leaves and which end fills
	assign obit = st.order ? st.sh[7] : st.sh[0];
	assign shin = st.order ? {st.sh[6:0], pin_in_i[CSP_P_SIN]}
		: {pin_in_i[CSP_P_SIN], st.sh[7:1]};
	// Phase picks the sampling edge in the active-high view
	assign samp = st.phase ? rise : fall;

	// Next state: register writes first, then shift events,
	// so a completion in the clearing cycle keeps the flag set
	always_comb begin
		next_st = st;
		next_st.pclk = lvl;
		if (osc_tick_i) begin
			next_st.div = ~st.div;
		end
		next_st.rdata = CSP_ZERO4;
		if (rd_i) begin
			unique case (addr_i)
				CSP_A_CTRL: next_st.rdata = {1'b0, st.soe, st.run, st.pfs};
				CSP_A_CFG: next_st.rdata = {st.order, st.phase, st.mode};
				CSP_A_DLO: next_st.rdata = st.sh[3:0];
				CSP_A_DHI: next_st.rdata = st.sh[7:4];
				CSP_A_IEN: next_st.rdata = {3'h0, st.ien};
				CSP_A_IFL: next_st.rdata = {3'h0, st.flag};
				default: next_st.rdata = CSP_ZERO4;
			endcase
			if (addr_i == CSP_A_DHI) begin
				next_st.rdy = 1'b0;
			end
		end
		if (wr_i) begin
			unique case (addr_i)
				CSP_A_CTRL: begin
					next_st.pfs = wdata_i[CSP_B_PFS];
					next_st.soe = wdata_i[CSP_B_SOE];
				end
				CSP_A_CFG: begin
					next_st.mode = wdata_i[CSP_B_MODE +: 2];
					next_st.phase = wdata_i[CSP_B_PHASE];
					next_st.order = wdata_i[CSP_B_ORDER];
				end
				CSP_A_DLO: next_st.sh[3:0] = wdata_i;
				CSP_A_DHI: begin
					next_st.sh[7:4] = wdata_i;
					next_st.rdy = 1'b0;
				end
				CSP_A_IEN: next_st.ien = wdata_i[CSP_B_IRQ];
				CSP_A_IFL: begin
					if (wdata_i[CSP_B_IRQ]) begin
						next_st.flag = 1'b0;
					end
				end
				default: next_st.sh = st.sh;
			endcase
		end
		// Trigger starts a fresh group of eight from an idle clock
		if (trig) begin
			next_st.run = 1'b1;
			next_st.cnt = 3'h0;
			next_st.clk = 1'b0;
			next_st.rdy = 1'b1;
			next_st.serial_out_pin = obit;
		end else begin
			if (master && mtick && st.run) begin
				next_st.clk = ~st.clk;
			end
			// Output bit changes on the active-going edge
			if (rise) begin
				next_st.serial_out_pin = obit;
				if (!master) begin
					next_st.rdy = 1'b0;
				end
			end
			if (samp) begin
				next_st.sh = shin;
			end
			// Each falling edge closes one cycle; eighth one ends it
			if (fall) begin
				next_st.cnt = st.cnt + 3'h1;
				if (st.cnt == CSP_CNT_LAST) begin
					next_st.run = 1'b0;
					next_st.flag = 1'b1;
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st <= CSP_RST;
		end else begin
			st <= next_st;
		end
	end

	// Pin sharing; with port select low the general port owns all
	always_comb begin
		pin_out_o = gpio_out_i;
		pin_oe_o = gpio_oe_i;
		if (st.pfs) begin
			pin_out_o[CSP_P_SIN] = 1'b0;
			pin_oe_o[CSP_P_SIN] = 1'b0;
			if (st.soe) begin
				pin_out_o[CSP_P_SERIAL_OUT_PIN] = st.serial_out_pin;
				pin_oe_o[CSP_P_SERIAL_OUT_PIN] = 1'b1;
			end
			pin_out_o[CSP_P_SCLK] = POS_POL ? st.clk : ~st.clk;
			pin_oe_o[CSP_P_SCLK] = master;
			if (!master) begin
				pin_out_o[CSP_P_RDY] = POS_POL ? st.rdy : ~st.rdy;
				pin_oe_o[CSP_P_RDY] = 1'b1;
			end
		end
	end

	assign rdata_o = st.rdata;
	// Flag is kept even when masked; only the request is gated
	assign irq_o = st.flag && st.ien;

	// Trigger write followed by the armed state
	sequence s_trig;
		trig ##1 st.run;
	endsequence

	a_trig_fresh_count: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) trig |-> s_trig ##0 st.cnt == 3'h0)
		else $error("trigger did not restart the count");

	a_trig_ready_up: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) trig |=> st.rdy)
		else $error("ready not raised after trigger");

	a_end_on_eighth: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		st.run && !trig ##1 !st.run |-> $past(st.cnt) == 3'h7)
		else $error("transfer ended on wrong cycle count");

	a_flag_on_done: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		st.run && !trig ##1 !st.run |-> st.flag)
		else $error("completion did not set the flag");

	a_idle_clock_pin: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) st.pfs && master && !st.run
		|-> pin_out_o[CSP_P_SCLK] == !POS_POL && pin_oe_o[CSP_P_SCLK])
		else $error("master clock pin not parked idle");

	a_mask_late_clk: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) !st.run && !wr_i |=> $stable(st.sh))
		else $error("shift register moved outside a transfer");

	a_serial_out_pin_gated: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) !(st.pfs && st.soe)
		|-> pin_oe_o[CSP_P_SERIAL_OUT_PIN] == gpio_oe_i[CSP_P_SERIAL_OUT_PIN])
		else $error("serial out drove a port pin while disabled");

	a_reset_port_use: assert property (@(posedge clk_i)
		!rst_b_i |=> !st.pfs && st.mode == CSP_M_SLAVE && !st.flag)
		else $error("reset did not return pins to port use");

	a_flag_clear_w1: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) wr_i && addr_i == CSP_A_IFL
		&& !wdata_i[CSP_B_IRQ] && st.flag |=> st.flag)
		else $error("writing zero cleared the flag");

	// Pin ownership: serial use only while port select is set
	a_port_default: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) !st.pfs
		|-> pin_oe_o == gpio_oe_i && pin_out_o == gpio_out_i)
		else $error("port pins left the general port while deselected");

	a_sin_input_only: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) st.pfs |-> !pin_oe_o[CSP_P_SIN])
		else $error("serial in pin was driven");

	a_gp3_master: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) st.pfs && master
		|-> pin_oe_o[CSP_P_RDY] == gpio_oe_i[CSP_P_RDY]
		&& pin_out_o[CSP_P_RDY] == gpio_out_i[CSP_P_RDY])
		else $error("ready pin taken over in master mode");

	a_serial_out_pin_drives: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) st.pfs && st.soe
		|-> pin_oe_o[CSP_P_SERIAL_OUT_PIN] && pin_out_o[CSP_P_SERIAL_OUT_PIN] == st.serial_out_pin)
		else $error("serial out pin not driven from the shift data");

	a_ready_pin_drive: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) st.pfs && !master
		|-> pin_oe_o[CSP_P_RDY]
		&& pin_out_o[CSP_P_RDY] == (POS_POL ? st.rdy : !st.rdy))
		else $error("ready pin not driven in slave mode");

	// Clock generation and the eight-cycle count
	sequence s_master_step;
		master && st.run && mtick && !trig;
	endsequence

	sequence s_last_fall;
		fall && st.cnt == CSP_CNT_LAST && !trig;
	endsequence

	a_master_toggle: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) s_master_step |=> $changed(st.clk))
		else $error("master clock missed a tick");

	a_clock_still: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) !(st.run && mtick) && !trig
		|=> $stable(st.clk))
		else $error("clock moved outside a transfer");

	a_count_step: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) fall && !trig
		|=> st.cnt == $past(st.cnt) + 3'h1)
		else $error("cycle count did not advance on a closing edge");

	a_stop_after_eight: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) s_last_fall |=> !st.run && st.flag)
		else $error("transfer did not stop after eight cycles");

	// Shift steps, ready handling and the interrupt flag
	a_msb_shift_step: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) samp && !wr_i && st.order
		|=> st.sh == {$past(st.sh[6:0]), $past(pin_in_i[CSP_P_SIN])})
		else $error("MSB-first step took the wrong bits");

	a_lsb_shift_step: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) samp && !wr_i && !st.order
		|=> st.sh == {$past(pin_in_i[CSP_P_SIN]), $past(st.sh[7:1])})
		else $error("LSB-first step took the wrong bits");

	a_no_idle_shift: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) st.run && !samp && !wr_i |=> $stable(st.sh))
		else $error("shift register moved off its sampling edge");

	a_ready_first_edge: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) !master && rise && !trig |=> !st.rdy)
		else $error("ready stayed active after the first clock");

	a_ready_high_nibble: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		(rd_i || wr_i) && addr_i == CSP_A_DHI |=> !st.rdy)
		else $error("ready stayed active after a high nibble access");

	a_irq_masked: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) !st.ien |-> !irq_o)
		else $error("masked interrupt reached the request line");

	a_flag_sticky: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) st.flag
		&& !(wr_i && addr_i == CSP_A_IFL && wdata_i[CSP_B_IRQ]) |=> st.flag)
		else $error("flag dropped without a clearing write");

	a_flag_one_clears: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) wr_i && addr_i == CSP_A_IFL
		&& wdata_i[CSP_B_IRQ] && !fall |=> !st.flag)
		else $error("writing one did not clear the flag");

	a_rdata_idle: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) !rd_i |=> rdata_o == CSP_ZERO4)
		else $error("read data stood without a read");
endmodule

//--- csp_pkg.sv
// Constants and state type of the clocked serial shift port
package csp_pkg;
	// Register addresses
	localparam logic [15:0] CSP_A_CTRL = 16'hff70;
	localparam logic [15:0] CSP_A_CFG = 16'hff71;
	localparam logic [15:0] CSP_A_DLO = 16'hff72;
	localparam logic [15:0] CSP_A_DHI = 16'hff73;
	localparam logic [15:0] CSP_A_IEN = 16'hffe2;
	localparam logic [15:0] CSP_A_IFL = 16'hfff2;
	// Field positions of serial_control
	localparam int CSP_B_PFS = 0;
	localparam int CSP_B_TRIG = 1;
	localparam int CSP_B_SOE = 2;
	// Field positions of serial_clock_config
	localparam int CSP_B_MODE = 0;
	localparam int CSP_B_PHASE = 2;
	localparam int CSP_B_ORDER = 3;
	// Bit of serial_irq_enable and serial_irq_flag
	localparam int CSP_B_IRQ = 0;
	// Pin positions on the shared port
	localparam int CSP_P_SIN = 0;
	localparam int CSP_P_SERIAL_OUT_PIN = 1;
	localparam int CSP_P_SCLK = 2;
	localparam int CSP_P_RDY = 3;
	// Clock modes
	localparam logic [1:0] CSP_M_SLAVE = 2'h0;
	localparam logic [1:0] CSP_M_TIMER = 2'h1;
	localparam logic [1:0] CSP_M_HALF = 2'h2;
	localparam logic [1:0] CSP_M_OSC = 2'h3;
	// Index of the last of eight clock cycles
	localparam logic [2:0] CSP_CNT_LAST = 3'h7;
	localparam logic [3:0] CSP_ZERO4 = 4'h0;

	// Whole state of the block
	typedef struct packed {
		logic pfs;
		logic soe;
		logic run;
		logic [1:0] mode;
		logic phase;
		logic order;
		logic [7:0] sh;
		logic [2:0] cnt;
		logic flag;
		logic ien;
		logic clk;
		logic pclk;
		logic rdy;
		logic div;
		logic serial_out_pin;
		logic [3:0] rdata;
	} csp_state_t;

	// Reset: port use, slave mode, idle clock, flags clear
	localparam csp_state_t CSP_RST = '0;
endpackage

//--- csp_partner_master.sv
// External serial master model that clocks the port in slave mode
`timescale 1ns/100ps
module csp_partner_master (
	// Clock and wires toward the port
	input wire logic clk_i,
	input wire logic serial_out_pin_i,
	output logic sclk_o,
	output logic sdat_o,
	output logic [7:0] rx_o
);
	localparam int HALF = 100;
	// Clock idles low and stands still between frames
	initial begin
		sclk_o = 1'b0;
		sdat_o = 1'b0;
		rx_o = 8'h00;
	end
	// Sends MSB first; extra pulses repeat the byte and are not recorded.
	// Serial out moves just after the rising edge, so it is taken as the
	// clock falls, half a period away from the change.
	task automatic frame(input logic [7:0] tx, input int n);
		for (int i = 0; i < n; i++) begin
			sdat_o <= tx[7 - (i % 8)];
			repeat (HALF) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (HALF) @(posedge clk_i);
			sclk_o <= 1'b0;
			if (i < 8)
				rx_o <= {rx_o[6:0], serial_out_pin_i};
		end
		sdat_o <= ~sdat_o; // Released line never shows the last bit
	endtask
endmodule

//--- test_clocked_serial_shift_port.sv
// Self-checking bench for the clocked serial shift port
`timescale 1ns/100ps
module test_clocked_serial_shift_port;
	import csp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [3:0] wdata_i = 4'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic osc_tick_i = 1'b0;
	logic tmr2_uf_i = 1'b0;
	logic [3:0] gpio_out_i = 4'h0;
	logic [3:0] gpio_oe_i = 4'h0;
	logic [3:0] rdata_o, pin_out_o, pin_oe_o, pin_in_i;
	logic irq_o, sclk, sdat, last_clk;
	logic [7:0] rx;
	logic [15:0] ra[5] = '{CSP_A_CTRL, CSP_A_CFG, CSP_A_IEN, CSP_A_IFL,
		16'hff74};
	int error_cnt = 0;
	int total_checks = 0;
	int edges = 0;
	always #2.5 clk_i = ~clk_i;
	// Wire levels: an enabled port driver owns pins 1 to 3; pin 0 always carries sdat
	assign pin_in_i = {pin_oe_o[3] ? pin_out_o[3] : gpio_out_i[3],
		pin_oe_o[2] ? pin_out_o[2] : sclk,
		pin_oe_o[1] ? pin_out_o[1] : 1'b0, sdat};
	csp_shift_port dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.osc_tick_i(osc_tick_i), .tmr2_uf_i(tmr2_uf_i),
		.gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pin_in_i(pin_in_i),
		.pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o));
	csp_partner_master pm (.clk_i(clk_i), .serial_out_pin_i(pin_out_o[1]),
		.sclk_o(sclk), .sdat_o(sdat), .rx_o(rx));
	// Count rising clock edges the port drives in master mode
	always @(posedge clk_i) begin
		last_clk <= pin_out_o[2];
		if (pin_oe_o[2] && pin_out_o[2] && !last_clk)
			edges <= edges + 1;
	end
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [3:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [3:0] e,
		input string n);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(n, {4'h0, e}, {4'h0, rdata_o});
	endtask
	// Slow clock sources tick every 100 cycles to stay at 2 MHz
	task automatic tick(input int n);
		repeat (n) begin
			repeat (99) @(posedge clk_i);
			osc_tick_i <= 1'b1;
			tmr2_uf_i <= 1'b1;
			@(posedge clk_i);
			osc_tick_i <= 1'b0;
			tmr2_uf_i <= 1'b0;
		end
	endtask
	// Reference model: queued bits folded in the chosen bit order
	function automatic int model_rx(input bit q[$], input bit msb);
		int v;
		v = 0;
		foreach (q[i])
			v = msb ? ((v << 1) | int'(q[i])) & 255
				: (v >> 1) | (int'(q[i]) << 7);
		return v;
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Cut a hang short; the tests need about 14k cycles, this allows 40k
	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end
	// Main sequence
	initial begin
		logic [7:0] tx, rb;
		int base;
		bit sent_q[$];
		int exp_rx;
		void'($urandom(32'hca79d53a));
		@(posedge clk_i);
		gpio_out_i <= 4'($urandom);
		gpio_oe_i <= 4'($urandom);
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		#1 chk("pins", {gpio_oe_i, gpio_out_i}, {pin_oe_o, pin_out_o});
		foreach (ra[i]) rd(ra[i], 4'h0, "reset_reg");
		$display("test reset done");
		tx = 8'($urandom);
		rb = 8'($urandom);
		wr(CSP_A_CFG, 4'hc);
		wr(CSP_A_DLO, tx[3:0]);
		wr(CSP_A_DHI, tx[7:4]);
		wr(CSP_A_CTRL, 4'h3);
		repeat (2) @(posedge clk_i);
		#1 chk("ready", 8'h03, {6'h0, pin_oe_o[3], pin_out_o[3]});
		chk("serial_out_pin_off", {7'h0, gpio_oe_i[1]}, {7'h0, pin_oe_o[1]});
		wr(CSP_A_CTRL, 4'h7);
		wr(CSP_A_IEN, 4'h1);
		pm.frame(rb, 10);
		repeat (4) @(posedge clk_i);
		#1 chk("irq", 8'h01, {7'h0, irq_o});
		chk("ready_end", 8'h00, {7'h0, pin_out_o[3]});
		chk("tx", tx, rx);
		for (int i = 0; i < 8; i++)
			sent_q.push_back(rb[7 - i]);
		exp_rx = model_rx(sent_q, 1'b1);
		rd(CSP_A_DLO, 4'(exp_rx), "rx_lo");
		rd(CSP_A_DHI, 4'(exp_rx >> 4), "rx_hi");
		wr(CSP_A_IFL, 4'h0);
		rd(CSP_A_IFL, 4'h1, "flag_w0");
		wr(CSP_A_IFL, 4'h1);
		rd(CSP_A_IFL, 4'h0, "flag_w1");
		$display("test slave done");
		wr(CSP_A_IEN, 4'h0);
		for (int m = 3; m > 0; m--) begin
			wr(CSP_A_IFL, 4'h1);
			wr(CSP_A_CFG, 4'(m));
			wr(CSP_A_CTRL, 4'h7);
			base = edges;
			tick(40);
			chk("pulses", 8'h08, 8'(edges - base));
			chk("idle", 8'h02, {6'h0, pin_oe_o[2], pin_out_o[2]});
			chk("gp3", {7'h0, gpio_oe_i[3]}, {7'h0, pin_oe_o[3]});
			rd(CSP_A_IFL, 4'h1, "flag");
			chk("masked", 8'h00, {7'h0, irq_o});
		end
		$display("test master done");
		finish_test();
	end
endmodule
